// ### design/wpfl_params.svh
// Contract
// - fast_quad_mode resets to one, active
// - lock_scheme_select picks range or individual locks
// - Reset sets every individual lock bit
// - Write-class frames must end on byte boundary
// - Nothing acts while power-on reset asserted
// - Write-class commands rejected during power-up delay
// - write_latch clear after power-up
// - Write-class commands need write_latch set
// - Finished operation clears write_latch
// - Deep sleep ignores all but wake_command
// - Status write updates range and lock fields
// - write_guard_pin joins lock_method_bits for status
// - Lock-down until reset; one-time lock permanent
// - Block codes protect 2 to 64 blocks
// - Code 000 none, 111 whole array
// - Fine grain codes protect 4 to 32 kB
// - complement inverts the protected region
// - Refuse operations touching protected addresses
// - Method 01 locks status while pin low; code locks only while QE bit is clear
`ifndef WPFL_PARAMS_SVH
`define WPFL_PARAMS_SVH

`define WPFL_OP_WREN 8'h06
`define WPFL_OP_WREN_VOL 8'h50
`define WPFL_OP_WRDI 8'h04
`define WPFL_OP_WRSR 8'h01
`define WPFL_OP_PP 8'h02
`define WPFL_OP_SE 8'h20
`define WPFL_OP_BE32 8'h52
`define WPFL_OP_BE 8'hd8
`define WPFL_OP_CE 8'hc7
`define WPFL_OP_CE_ALT 8'h60
`define WPFL_OP_DP 8'hb9
`define WPFL_OP_WAKE 8'hab
`define WPFL_OP_RST_EN 8'h66
`define WPFL_OP_RST 8'h99

`define WPFL_KIND_NONE 3'h0
`define WPFL_KIND_PP 3'h1
`define WPFL_KIND_SE 3'h2
`define WPFL_KIND_BE32 3'h3
`define WPFL_KIND_BE 3'h4
`define WPFL_KIND_CE 3'h5
`define WPFL_KIND_WRSR 3'h6

`define WPFL_REG_STATUS 4'h0
`define WPFL_REG_STATE 4'h1
`define WPFL_REG_LOCK 4'h2

`define WPFL_SR1_RST 8'h00
`define WPFL_SR2_RST 8'h00
`define WPFL_SR3_RST 8'h10

`define WPFL_SR1_BP_LSB 2
`define WPFL_SR1_TB 5
`define WPFL_SR1_SEC 6
`define WPFL_SR1_SRP0 7
`define WPFL_SR2_SRP1 0
`define WPFL_SR2_QE 1
`define WPFL_SR2_CMP 6
`define WPFL_SR2_LB_MASK 8'h3c
`define WPFL_SR3_WPS 2
`define WPFL_SR3_HFQ 4

`define WPFL_SECTORS 12'h800
`define WPFL_BLOCK_SECT 12'h010
`define WPFL_BLOCKS 128

`define WPFL_CLK_MHZ 250
`define WPFL_TPUW_US 1000
`define WPFL_BUSY_CYCLES 64

`endif

// ### design/wpfl_pkg.sv
`default_nettype none
package wpfl_pkg;

    typedef enum logic [2:0] {
        WPFL_IDLE = 3'b001,
        WPFL_BUSY = 3'b010,
        WPFL_DEEP = 3'b100
    } wpfl_mode_t;

    typedef struct packed {
        logic [2:0] sclk_sync;
        logic [2:0] cs_sync;
        logic [1:0] di_sync;
        logic [7:0] shift;
        logic [2:0] bit_cnt;
        logic in_frame;
        logic frame_start;
        logic frame_end;
        logic frame_aligned;
        logic byte_valid;
        logic [7:0] byte_data;
    } wpfl_rx_state_t;

    typedef struct packed {
        wpfl_mode_t mode;
        logic [1:0] wp_sync;
        logic [7:0] sr1;
        logic [7:0] sr2;
        logic [7:0] sr3;
        logic write_latch;
        logic [31:0] puw_cnt;
        logic [15:0] busy_cnt;
        logic [2:0] byte_cnt;
        logic [7:0] opcode;
        logic [23:0] addr;
        logic [7:0] new_sr1;
        logic [7:0] new_sr2;
        logic [7:0] new_sr3;
        logic rst_armed;
        logic [127:0] locks;
        logic [6:0] lock_idx;
        logic [31:0] rdata;
        logic op_start;
        logic [2:0] op_kind;
        logic [23:0] op_addr;
        logic refused;
        logic last_refused;
    } wpfl_core_state_t;

endpackage : wpfl_pkg
`default_nettype wire

// ### design/wpfl_core_if.sv
`timescale 1ns/1ns
`default_nettype none
interface wpfl_core_if;
    logic frame_start;
    logic frame_end;
    logic frame_aligned;
    logic byte_valid;
    logic [7:0] byte_data;
    logic cmp;
    logic sec;
    logic tb;
    logic lock_scheme_select;
    logic [2:0] bp;
    logic [127:0] locks;
    logic [10:0] req_lo;
    logic [10:0] req_hi;
    logic hit;

    modport rx (
        output frame_start, frame_end, frame_aligned, byte_valid, byte_data
    );
    modport dec (
        input cmp, sec, tb, lock_scheme_select, bp, locks, req_lo, req_hi,
        output hit
    );
    modport core (
        input frame_start, frame_end, frame_aligned, byte_valid, byte_data,
        input hit,
        output cmp, sec, tb, lock_scheme_select, bp, locks, req_lo, req_hi
    );
endinterface : wpfl_core_if
`default_nettype wire

// ### design/wpfl_spi_rx.sv
`timescale 1ns/1ns
`default_nettype none
module wpfl_spi_rx (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic spi_clk_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_di_in,
    wpfl_core_if.rx link
);
    wpfl_pkg::wpfl_rx_state_t s_reg;
    wpfl_pkg::wpfl_rx_state_t s_next;

    logic sclk_rise;
    logic cs_fall;
    logic cs_rise;

    always_comb begin
        s_next = s_reg;
        s_next.frame_start = 1'b0;
        s_next.frame_end = 1'b0;
        s_next.byte_valid = 1'b0;
        s_next.sclk_sync = {s_reg.sclk_sync[1:0], spi_clk_in};
        s_next.cs_sync = {s_reg.cs_sync[1:0], spi_cs_n_in};
        s_next.di_sync = {s_reg.di_sync[0], spi_di_in};
        sclk_rise = s_reg.sclk_sync[1] & ~s_reg.sclk_sync[2];
        cs_fall = s_reg.cs_sync[2] & ~s_reg.cs_sync[1];
        cs_rise = ~s_reg.cs_sync[2] & s_reg.cs_sync[1];
        if (cs_fall) begin
            s_next.in_frame = 1'b1;
            s_next.bit_cnt = 3'h0;
            s_next.frame_start = 1'b1;
        end else if (cs_rise && s_reg.in_frame) begin
            s_next.in_frame = 1'b0;
            s_next.frame_end = 1'b1;
            s_next.frame_aligned = (s_reg.bit_cnt == 3'h0);
        end else if (s_reg.in_frame && !s_reg.cs_sync[1] && sclk_rise) begin
            s_next.shift = {s_reg.shift[6:0], s_reg.di_sync[1]};
            s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
            if (s_reg.bit_cnt == 3'h7) begin
                s_next.byte_valid = 1'b1;
                s_next.byte_data = {s_reg.shift[6:0], s_reg.di_sync[1]};
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            s_reg <= '0;
            s_reg.cs_sync <= 3'h7;
        end else begin
            s_reg <= s_next;
        end
    end

    assign link.frame_start = s_reg.frame_start;
    assign link.frame_end = s_reg.frame_end;
    assign link.frame_aligned = s_reg.frame_aligned;
    assign link.byte_valid = s_reg.byte_valid;
    assign link.byte_data = s_reg.byte_data;
endmodule : wpfl_spi_rx
`default_nettype wire

// ### design/wpfl_range_check.sv
`timescale 1ns/1ns
`default_nettype none
`include "wpfl_params.svh"
module wpfl_range_check (
    wpfl_core_if.dec prot
);
    // Size of the protected region in 4 kB sectors
    function automatic logic [11:0] wpfl_span(input logic sec,
                                             input logic [2:0] bp);
        logic [11:0] n;
        n = 12'h000;
        if (bp == 3'h7) begin
            n = `WPFL_SECTORS;
        end else if (bp != 3'h0 && !sec) begin
            n = 12'(`WPFL_BLOCK_SECT << bp);
        end else if (bp != 3'h0) begin
            n = (bp >= 3'h4) ? 12'h008 : 12'(12'h001 << (bp - 3'h1));
        end
        return n;
    endfunction : wpfl_span

    logic [11:0] n;
    logic [11:0] lo;
    logic [11:0] hi;
    logic [11:0] rlo;
    logic [11:0] rhi;
    logic range_hit;
    logic lock_hit;

    always_comb begin
        n = wpfl_span(prot.sec, prot.bp);
        lo = prot.tb ? 12'h000 : (`WPFL_SECTORS - n);
        hi = prot.tb ? (n - 12'h001) : (`WPFL_SECTORS - 12'h001);
        rlo = {1'b0, prot.req_lo};
        rhi = {1'b0, prot.req_hi};
        if (!prot.cmp) begin
            range_hit = (n != 12'h000) && (rlo <= hi) && (rhi >= lo);
        end else begin
            range_hit = (n == 12'h000) || (rlo < lo) || (rhi > hi);
        end
        lock_hit = 1'b0;
        for (int i = 0; i < `WPFL_BLOCKS; i++) begin
            if (prot.locks[i] && (7'(i) >= prot.req_lo[10:4])
                && (7'(i) <= prot.req_hi[10:4])) begin
                lock_hit = 1'b1;
            end
        end
    end

    assign prot.hit = prot.lock_scheme_select ? lock_hit : range_hit;
endmodule : wpfl_range_check
`default_nettype wire

// ### design/serial_flash_write_protect.sv
`timescale 1ns/1ns
`default_nettype none
`include "wpfl_params.svh"
module serial_flash_write_protect #(
    parameter int unsigned PUW_CYCLES = `WPFL_TPUW_US * `WPFL_CLK_MHZ,
    parameter int unsigned BUSY_CYCLES = `WPFL_BUSY_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic spi_clk_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_di_in,
    input wire logic write_guard_pin_n_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    output logic busy_out,
    output logic write_latch_out,
    output logic deep_sleep_state_out,
    output logic fast_quad_mode_out,
    output logic op_start_out,
    output logic [2:0] op_kind_out,
    output logic [23:0] op_addr_out,
    output logic cmd_refused_out
);
    wpfl_core_if core_bus ();

    wpfl_pkg::wpfl_core_state_t s_reg;
    wpfl_pkg::wpfl_core_state_t s_next;

    logic puw_done;
    logic sr_locked;
    logic is_erase_prog;
    logic enough_bytes;
    logic [2:0] kind;
    logic [10:0] sect;

    wpfl_spi_rx u_rx (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .spi_clk_in(spi_clk_in),
        .spi_cs_n_in(spi_cs_n_in),
        .spi_di_in(spi_di_in),
        .link(core_bus.rx)
    );

    wpfl_range_check u_range (
        .prot(core_bus.dec)
    );

    // Opcode to operation kind; none for anything not program/erase
    function automatic logic [2:0] wpfl_kind(input logic [7:0] op);
        logic [2:0] k;
        k = `WPFL_KIND_NONE;
        case (op)
            `WPFL_OP_PP: k = `WPFL_KIND_PP;
            `WPFL_OP_SE: k = `WPFL_KIND_SE;
            `WPFL_OP_BE32: k = `WPFL_KIND_BE32;
            `WPFL_OP_BE: k = `WPFL_KIND_BE;
            `WPFL_OP_CE: k = `WPFL_KIND_CE;
            `WPFL_OP_CE_ALT: k = `WPFL_KIND_CE;
            default: k = `WPFL_KIND_NONE;
        endcase
        return k;
    endfunction : wpfl_kind

    assign core_bus.cmp = s_reg.sr2[`WPFL_SR2_CMP];
    assign core_bus.sec = s_reg.sr1[`WPFL_SR1_SEC];
    assign core_bus.tb = s_reg.sr1[`WPFL_SR1_TB];
    assign core_bus.bp = s_reg.sr1[`WPFL_SR1_BP_LSB +: 3];
    assign core_bus.lock_scheme_select = s_reg.sr3[`WPFL_SR3_WPS];
    assign core_bus.locks = s_reg.locks;

    // requested sector span from held opcode and address
    always_comb begin
        kind = wpfl_kind(s_reg.opcode);
        sect = s_reg.addr[22:12];
        core_bus.req_lo = sect;
        core_bus.req_hi = sect;
        case (kind)
            `WPFL_KIND_BE32: begin
                core_bus.req_lo = {sect[10:3], 3'h0};
                core_bus.req_hi = {sect[10:3], 3'h7};
            end
            `WPFL_KIND_BE: begin
                core_bus.req_lo = {sect[10:4], 4'h0};
                core_bus.req_hi = {sect[10:4], 4'hf};
            end
            `WPFL_KIND_CE: begin
                core_bus.req_lo = 11'h000;
                core_bus.req_hi = 11'h7ff;
            end
            default: begin
                core_bus.req_lo = sect;
                core_bus.req_hi = sect;
            end
        endcase
    end

    always_comb begin
        s_next = s_reg;
        s_next.op_start = 1'b0;
        s_next.refused = 1'b0;
        s_next.rdata = 32'h0000_0000;
        s_next.wp_sync = {s_reg.wp_sync[0], write_guard_pin_n_in};

        puw_done = (s_reg.puw_cnt == 32'(PUW_CYCLES));
        if (!puw_done) begin
            s_next.puw_cnt = s_reg.puw_cnt + 32'h1;
        end

        // status lock from pin and method bits
        sr_locked = s_reg.sr2[`WPFL_SR2_SRP1]
            | (s_reg.sr1[`WPFL_SR1_SRP0] & ~s_reg.sr2[`WPFL_SR2_QE]
               & ~s_reg.wp_sync[1]);

        is_erase_prog = (kind != `WPFL_KIND_NONE);
        enough_bytes = (kind == `WPFL_KIND_CE) || (s_reg.byte_cnt >= 3'h4);

        if (reg_rd_in) begin
            case (reg_addr_in)
                `WPFL_REG_STATUS: begin
                    s_next.rdata = {8'h00, s_reg.sr3, s_reg.sr2,
                        s_reg.sr1[7:2], s_reg.write_latch,
                        (s_reg.mode == wpfl_pkg::WPFL_BUSY)};
                end
                `WPFL_REG_STATE: begin
                    s_next.rdata = {25'h0, s_reg.last_refused,
                        s_reg.rst_armed, puw_done,
                        (s_reg.mode == wpfl_pkg::WPFL_DEEP),
                        sr_locked, s_reg.write_latch,
                        (s_reg.mode == wpfl_pkg::WPFL_BUSY)};
                end
                `WPFL_REG_LOCK: begin
                    s_next.rdata = {23'h0, s_reg.locks[s_reg.lock_idx],
                        1'b0, s_reg.lock_idx};
                end
                default: begin
                    s_next.rdata = 32'h0000_0000;
                end
            endcase
        end
        // Software sets or clears one block lock; bit 8 is the value
        if (reg_wr_in && reg_addr_in == `WPFL_REG_LOCK) begin
            s_next.lock_idx = reg_wdata_in[6:0];
            s_next.locks[reg_wdata_in[6:0]] = reg_wdata_in[8];
        end

        if (core_bus.frame_start) begin
            s_next.byte_cnt = 3'h0;
        end
        if (core_bus.byte_valid) begin
            case (s_reg.byte_cnt)
                3'h0: s_next.opcode = core_bus.byte_data;
                3'h1: begin
                    s_next.addr[23:16] = core_bus.byte_data;
                    s_next.new_sr1 = core_bus.byte_data;
                end
                3'h2: begin
                    s_next.addr[15:8] = core_bus.byte_data;
                    s_next.new_sr2 = core_bus.byte_data;
                end
                3'h3: begin
                    s_next.addr[7:0] = core_bus.byte_data;
                    s_next.new_sr3 = core_bus.byte_data;
                end
                default: begin
                end
            endcase
            if (s_reg.byte_cnt != 3'h7) begin
                s_next.byte_cnt = s_reg.byte_cnt + 3'h1;
            end
        end

        if (core_bus.frame_end && core_bus.frame_aligned
            && s_reg.byte_cnt != 3'h0) begin
            case (s_reg.mode)
                wpfl_pkg::WPFL_DEEP: begin
                    // only the wake command is heard
                    if (s_reg.opcode == `WPFL_OP_WAKE) begin
                        s_next.mode = wpfl_pkg::WPFL_IDLE;
                    end
                end
                wpfl_pkg::WPFL_BUSY: begin
                end
                wpfl_pkg::WPFL_IDLE: begin
                    s_next.rst_armed = (s_reg.opcode == `WPFL_OP_RST_EN);
                    if (is_erase_prog) begin
                        if (!enough_bytes) begin
                        end else if (!puw_done || !s_reg.write_latch
                                     || core_bus.hit) begin
                            s_next.refused = 1'b1;
                            s_next.last_refused = 1'b1;
                        end else begin
                            s_next.mode = wpfl_pkg::WPFL_BUSY;
                            s_next.busy_cnt = 16'h0000;
                            s_next.op_start = 1'b1;
                            s_next.op_kind = kind;
                            s_next.op_addr = s_reg.addr;
                            s_next.last_refused = 1'b0;
                        end
                    end
                    case (s_reg.opcode)
                        `WPFL_OP_WREN, `WPFL_OP_WREN_VOL: begin
                            if (puw_done) begin
                                s_next.write_latch = 1'b1;
                            end else begin
                                s_next.refused = 1'b1;
                                s_next.last_refused = 1'b1;
                            end
                        end
                        `WPFL_OP_WRDI: begin
                            s_next.write_latch = 1'b0;
                        end
                        `WPFL_OP_WRSR: begin
                            if (!puw_done || !s_reg.write_latch || sr_locked) begin
                                s_next.refused = 1'b1;
                                s_next.last_refused = 1'b1;
                            end else if (s_reg.byte_cnt >= 3'h2) begin
                                // busy and latch bits not stored
                                s_next.sr1 = {s_reg.new_sr1[7:2], 2'b00};
                                if (s_reg.byte_cnt >= 3'h3) begin
                                    // One-time lock bits only ever set
                                    s_next.sr2 = (s_reg.new_sr2
                                        & ~`WPFL_SR2_LB_MASK)
                                        | ((s_reg.sr2 | s_reg.new_sr2)
                                        & `WPFL_SR2_LB_MASK);
                                end
                                if (s_reg.byte_cnt >= 3'h4) begin
                                    s_next.sr3 = s_reg.new_sr3;
                                end
                                s_next.mode = wpfl_pkg::WPFL_BUSY;
                                s_next.busy_cnt = 16'h0000;
                                s_next.op_start = 1'b1;
                                s_next.op_kind = `WPFL_KIND_WRSR;
                                s_next.op_addr = 24'h000000;
                                s_next.last_refused = 1'b0;
                            end
                        end
                        `WPFL_OP_DP: begin
                            s_next.mode = wpfl_pkg::WPFL_DEEP;
                        end
                        `WPFL_OP_RST: begin
                            if (s_reg.rst_armed) begin
                                s_next.write_latch = 1'b0;
                                s_next.locks = '1;
                                if (s_reg.sr2[`WPFL_SR2_SRP1]
                                    && !s_reg.sr1[`WPFL_SR1_SRP0]) begin
                                    s_next.sr2[`WPFL_SR2_SRP1] = 1'b0;
                                end
                            end
                        end
                        default: begin
                        end
                    endcase
                end
                default: begin
                    s_next.mode = wpfl_pkg::WPFL_IDLE;
                end
            endcase
        end

        if (s_reg.mode == wpfl_pkg::WPFL_BUSY) begin
            s_next.busy_cnt = s_reg.busy_cnt + 16'h0001;
            if (s_reg.busy_cnt == 16'(BUSY_CYCLES - 1)) begin
                s_next.mode = wpfl_pkg::WPFL_IDLE;
                s_next.write_latch = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            s_reg <= '0;
            s_reg.mode <= wpfl_pkg::WPFL_IDLE;
            s_reg.write_latch <= 1'b0;
            s_reg.sr1 <= `WPFL_SR1_RST;
            s_reg.sr2 <= `WPFL_SR2_RST;
            s_reg.sr3 <= `WPFL_SR3_RST;
            s_reg.locks <= '1;
            s_reg.wp_sync <= 2'b11;
        end else begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata_out = s_reg.rdata;
    assign busy_out = s_reg.mode[1];
    assign write_latch_out = s_reg.write_latch;
    assign deep_sleep_state_out = s_reg.mode[2];
    assign fast_quad_mode_out = s_reg.sr3[`WPFL_SR3_HFQ];
    assign op_start_out = s_reg.op_start;
    assign op_kind_out = s_reg.op_kind;
    assign op_addr_out = s_reg.op_addr;
    assign cmd_refused_out = s_reg.refused;
endmodule : serial_flash_write_protect
`default_nettype wire

// ### verification/wpfl_sva.sv
`timescale 1ns/1ns
`default_nettype none
module wpfl_sva #(
    parameter int unsigned PUW_CYCLES = 20,
    parameter int unsigned BUSY_CYCLES = 8
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic busy_out,
    input wire logic write_latch_out,
    input wire logic deep_sleep_state_out,
    input wire logic fast_quad_mode_out,
    input wire logic op_start_out,
    input wire logic cmd_refused_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    logic [31:0] up_reg;
    logic [15:0] run_reg;
    // Saturates so the delay window closes for good
    always_ff @(posedge ref_clk_in) begin
        up_reg <= !reset_n_in ? 32'h0 : up_reg + 32'(up_reg < PUW_CYCLES);
        run_reg <= busy_out ? run_reg + 16'h1 : 16'h0;
    end
    sequence s_accept;
        op_start_out ##0 busy_out;
    endsequence
    sequence s_finish;
        !busy_out ##0 !write_latch_out;
    endsequence
    a_reset_quiet: assert property (disable iff (1'b0)
        !reset_n_in |=> fast_quad_mode_out && !write_latch_out
        && !op_start_out && !cmd_refused_out)
        else $error("reset state wrong");
    a_start_latch: assert property (op_start_out |->
        $past(write_latch_out)) else $error("start without latch");
    a_start_busy: assert property (op_start_out |-> s_accept)
        else $error("start without busy");
    a_busy_length: assert property ($fell(busy_out) |->
        run_reg == BUSY_CYCLES) else $error("busy length wrong");
    a_finish_clear: assert property ($fell(busy_out) |-> s_finish)
        else $error("latch kept after finish");
    a_refuse_keep: assert property (cmd_refused_out |->
        $stable(write_latch_out) && !busy_out) else $error("refusal acted");
    a_deep_idle: assert property (deep_sleep_state_out
        && $past(deep_sleep_state_out) |-> $stable(write_latch_out)
        && !op_start_out) else $error("acted in deep sleep");
    a_delay_locked: assert property (up_reg < PUW_CYCLES |->
        !write_latch_out && !op_start_out) else $error("write in delay");
endmodule : wpfl_sva
bind serial_flash_write_protect wpfl_sva #(.PUW_CYCLES(PUW_CYCLES),
    .BUSY_CYCLES(BUSY_CYCLES)) sva_u (.ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in), .busy_out(busy_out),
    .write_latch_out(write_latch_out), .op_start_out(op_start_out),
    .deep_sleep_state_out(deep_sleep_state_out),
    .fast_quad_mode_out(fast_quad_mode_out),
    .cmd_refused_out(cmd_refused_out));
`default_nettype wire

// ### verification/wpfl_host.sv
`timescale 1ns/1ns
`default_nettype none
module wpfl_host (
    output logic spi_clk_out,
    output logic spi_cs_n_out,
    output logic spi_di_out
);
    initial begin
        spi_clk_out = 1'b0;
        spi_cs_n_out = 1'b1;
        spi_di_out = 1'b0;
    end
    // whole bytes unless a fault is wanted
    task automatic send(input logic [31:0] d, input int bits);
        spi_cs_n_out = 1'b0;
        for (int i = 31; i > 31 - bits; i--) begin
            spi_di_out = d[i];
            #24 spi_clk_out = 1'b1;
            #24 spi_clk_out = 1'b0;
        end
        #24 spi_cs_n_out = 1'b1;
        // Released line shows the inverse, never a stale bit
        spi_di_out = ~spi_di_out;
    endtask : send
endmodule : wpfl_host
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic guard_n = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sck, cs_n, di, busy, write_latch, deep, fq, start, refd;
    logic [31:0] rdata;
    logic [2:0] kind;
    logic [23:0] oaddr;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int starts = 0;
    int refs = 0;
    initial forever #2 clk = ~clk;
    wpfl_host host_u (.spi_clk_out(sck), .spi_cs_n_out(cs_n),
        .spi_di_out(di));
    serial_flash_write_protect #(.PUW_CYCLES(400), .BUSY_CYCLES(8)) dut_u (
        .ref_clk_in(clk), .reset_n_in(rst_n), .spi_clk_in(sck),
        .spi_cs_n_in(cs_n), .spi_di_in(di), .write_guard_pin_n_in(guard_n),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .busy_out(busy),
        .write_latch_out(write_latch), .deep_sleep_state_out(deep),
        .fast_quad_mode_out(fq), .op_start_out(start), .op_kind_out(kind),
        .op_addr_out(oaddr), .cmd_refused_out(refd));
    task automatic conclude();
        if (fail_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude
    always @(posedge clk) begin
        cycles <= cycles + 1;
        starts <= starts + int'(start === 1'b1);
        refs <= refs + int'(refd === 1'b1);
        if (cycles == 30000) begin
            fail_count++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rd_reg
    task automatic cmd(input logic [31:0] d, input int n);
        host_u.send(d, n);
        repeat (12) @(posedge clk);
        for (int i = 0; i < 40 && busy !== 1'b0; i++) @(posedge clk);
        #1;
        chk(32'(busy), 32'h0);
    endtask : cmd
    task automatic wren();
        cmd(32'h06000000, 8);
    endtask : wren
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1 chk(32'(fq), 32'h1);
        chk(32'(write_latch), 32'h0);
        rd_reg(4'h0, 32'h00100000);
        wren();
        chk(32'(refs), 32'h1);
        repeat (400) @(posedge clk);
        #1;
        cmd(32'h06000000, 15);
        chk({write_latch, 31'(refs)}, 32'h1);
        cmd(32'h02000100, 32);
        chk(32'(refs), 32'h2);
        wren();
        chk(32'(write_latch), 32'h1);
        cmd(32'h02000100, 32);
        chk({8'h0, kind, oaddr[20:0]}, 32'h00200100);
        chk(32'(write_latch), 32'h0);
        wren();
        cmd(32'h01040010, 32);
        rd_reg(4'h0, 32'h00100004);
        wren();
        cmd(32'h207e0000, 32);
        chk(32'(refs), 32'h3);
        chk(32'(write_latch), 32'h1);
        cmd(32'h207df000, 32);
        chk(32'(oaddr), 32'h007df000);
        wren();
        cmd(32'h01444010, 32);
        wren();
        cmd(32'h20000000, 32);
        chk(32'(refs), 32'h4);
        cmd(32'h207ff000, 32);
        chk(32'(oaddr), 32'h007ff000);
        wren();
        cmd(32'hb9000000, 8);
        chk(32'(deep), 32'h1);
        cmd(32'h04000000, 8);
        chk(32'(write_latch), 32'h1);
        cmd(32'hab000000, 8);
        chk(32'(deep), 32'h0);
        wren();
        cmd(32'h01800010, 32);
        guard_n <= 1'b0;
        wren();
        cmd(32'h01000010, 32);
        chk(32'(refs), 32'h5);
        guard_n <= 1'b1;
        cmd(32'h01000010, 32);
        chk(32'(starts), 32'h7);
        wr_reg(4'h0, 32'hffffffff);
        rd_reg(4'h0, 32'h00100000);
        rd_reg(4'h1, 32'h00000010);
        wren();
        cmd(32'h01000014, 32);
        wren();
        cmd(32'h20050000, 32);
        chk(32'(refs), 32'h6);
        wr_reg(4'h2, 32'h00000005);
        rd_reg(4'h2, 32'h00000005);
        cmd(32'h20050000, 32);
        chk(32'(oaddr), 32'h00050000);
        wren();
        cmd(32'h01000114, 32);
        wren();
        cmd(32'h01000014, 32);
        chk(32'(refs), 32'h7);
        cmd(32'h66000000, 8);
        cmd(32'h99000000, 8);
        rd_reg(4'h1, 32'h00000050);
        rd_reg(4'h2, 32'h00000105);
        conclude();
    end
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
endmodule : testbench
`default_nettype wire
